// >>> include/ptmc_defines.svh
// Constants for the transmit test mode control block.
`ifndef PTMC_DEFINES_SVH
`define PTMC_DEFINES_SVH
`define PTMC_SEL_MSB      15
`define PTMC_SEL_LSB      13
`define PTMC_SEL_NORMAL   3'h0
`define PTMC_SEL_MODE1    3'h1
`define PTMC_SEL_MODE2    3'h2
`define PTMC_SEL_MODE3    3'h3
`define PTMC_DROOP_RUN    5'h0a
`define PTMC_PD_SETTLE    4'h4
`define PTMC_LED_AUTO     2'h0
`define PTMC_LED_HIGH     2'h1
`define PTMC_LED_LOW      2'h2
`define PTMC_SENSE_WAIT   4'h8
`define PTMC_STRAP_CATCH  2'h2
`define PTMC_STRAP_DONE   2'h3
`endif

// >>> include/ptmc_pkg.sv
// Types shared by the transmit test mode control block.
package ptmc_pkg;
	// Ternary line symbol: zero, plus one, minus one.
	typedef enum logic [1:0] {
		PTMC_SYM_ZERO  = 2'h0,
		PTMC_SYM_PLUS  = 2'h1,
		PTMC_SYM_MINUS = 2'h3
	} ptmc_sym_t;
	// Active transmit pattern after power-down is left.
	typedef enum logic [4:0] {
		PTMC_PAT_NORMAL = 5'h01,
		PTMC_PAT_ALT    = 5'h02,
		PTMC_PAT_DROOP  = 5'h04,
		PTMC_PAT_IDLE   = 5'h08,
		PTMC_PAT_ZERO   = 5'h10
	} ptmc_pat_t;
endpackage : ptmc_pkg

// >>> rtl/ptmc_led_polarity.sv
// LED polarity unit: autosense at reset, or forced active high or low.
`timescale 1ns/10ps
`include "ptmc_defines.svh"
module ptmc_led_polarity (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       soft_reset,
	input  wire logic [1:0] polarity_mode,
	input  wire logic       pin_in,
	input  wire logic       led_on,
	output logic            pin_out,
	output logic            pin_oe_n,
	output logic            sensed_active_low
);
	logic       sync1_reg, sync1_next;
	logic       sync2_reg, sync2_next;
	logic [3:0] wait_reg, wait_next;
	logic       sense_reg, sense_next;
	logic       drive_reg, drive_next;
	logic       out_reg, out_next;
	logic       act_low;

	// The pin level is synchronised; the sensing window releases the pin so
	// that the board pull decides the polarity, and a soft reset reopens it.
	always_comb begin
		sync1_next = pin_in;
		sync2_next = sync1_reg;
		wait_next  = wait_reg;
		sense_next = sense_reg;
		drive_next = drive_reg;
		if (soft_reset) begin
			wait_next  = 4'h0;
			drive_next = 1'b0;
		end else if (!drive_reg) begin
			if (wait_reg == `PTMC_SENSE_WAIT) begin
				sense_next = sync2_reg;
				drive_next = 1'b1;
			end else begin
				wait_next = wait_reg + 4'h1;
			end
		end
		// A pulled-high pin means the LED hangs from the supply: drive low.
		case (polarity_mode)
			`PTMC_LED_HIGH: act_low = 1'b0;
			`PTMC_LED_LOW:  act_low = 1'b1;
			default:        act_low = sense_reg;
		endcase
		out_next = act_low ? ~led_on : led_on;
	end

	// Registers only.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			wait_reg  <= 4'h0;
			sense_reg <= 1'b0;
			drive_reg <= 1'b0;
			out_reg   <= 1'b0;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			wait_reg  <= wait_next;
			sense_reg <= sense_next;
			drive_reg <= drive_next;
			out_reg   <= out_next;
		end
	end

	assign pin_out           = out_reg;
	assign pin_oe_n          = ~drive_reg;
	assign sensed_active_low = sense_reg;
endmodule : ptmc_led_polarity

// >>> rtl/ptmc_test_mode_ctrl.sv
// Transmit test pattern, power-down, strap and LED control of the PHY.
`timescale 1ns/10ps
`include "ptmc_defines.svh"
module ptmc_test_mode_ctrl (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        soft_reset,
	input  wire logic        soft_powerdown_request,
	output logic             soft_powerdown_ready_flag,
	input  wire logic        autoneg_enable_bit,
	input  wire logic        forced_link_enable,
	input  wire logic [15:0] test_pattern_control_reg,
	input  wire logic        tx_zero_symbol_enable,
	input  wire logic        far_end_loopback_enable,
	input  wire logic        tx_sym_valid,
	input  wire logic [1:0]  tx_sym_in,
	input  wire logic        idle_sym_valid,
	input  wire logic [1:0]  idle_sym_in,
	output logic [1:0]       tx_sym_out,
	output logic             tx_sym_out_valid,
	output logic             force_link_master,
	output logic [4:0]       active_pattern,
	input  wire logic        high_level_tx_strap,
	input  wire logic        sw_low_level_select,
	input  wire logic        an_low_level_result,
	output logic             tx_level_high,
	input  wire logic [1:0]  led_a_polarity,
	input  wire logic [1:0]  led_b_polarity,
	input  wire logic        led_a_on,
	input  wire logic        led_b_on,
	input  wire logic        indicator_out_a_in,
	output logic             indicator_out_a_out,
	output logic             indicator_out_a_oe_n,
	input  wire logic        indicator_out_b_in,
	output logic             indicator_out_b_out,
	output logic             indicator_out_b_oe_n,
	output logic [1:0]       led_sensed_active_low
);
	// Power-down, pattern and strap state.
	logic                pd_reg, pd_next;
	logic [3:0]          pd_cnt_reg, pd_cnt_next;
	ptmc_pkg::ptmc_pat_t pat_reg, pat_next;
	logic [4:0]          run_reg, run_next;
	logic                phase_reg, phase_next;
	logic [1:0]          sym_reg, sym_next;
	logic                sym_vld_reg, sym_vld_next;
	logic                strap_s1_reg, strap_s1_next;
	logic                strap_s2_reg, strap_s2_next;
	logic                strap_cap_reg, strap_cap_next;
	logic [1:0]          strap_wait_reg, strap_wait_next;
	logic                lvl_reg, lvl_next;

	// Decodes the select field and zero-symbol enable into a pattern.
	function automatic ptmc_pkg::ptmc_pat_t decode_pattern(
		input logic [15:0] ctl,
		input logic        zero_en
	);
		ptmc_pkg::ptmc_pat_t p;
		p = ptmc_pkg::PTMC_PAT_NORMAL;
		if (zero_en) begin
			p = ptmc_pkg::PTMC_PAT_ZERO;
		end else begin
			case (ctl[`PTMC_SEL_MSB:`PTMC_SEL_LSB])
				`PTMC_SEL_MODE1: p = ptmc_pkg::PTMC_PAT_ALT;
				`PTMC_SEL_MODE2: p = ptmc_pkg::PTMC_PAT_DROOP;
				`PTMC_SEL_MODE3: p = ptmc_pkg::PTMC_PAT_IDLE;
				default:         p = ptmc_pkg::PTMC_PAT_NORMAL;
			endcase
		end
		return p;
	endfunction : decode_pattern

	// Power-down handshake: the ready flag rises after a short settle while
	// the transmitter is held quiet; the pattern is latched only on exit so
	// that half-written settings never reach the line.
	always_comb begin
		pd_next     = pd_reg;
		pd_cnt_next = pd_cnt_reg;
		pat_next    = pat_reg;
		if (soft_powerdown_request) begin
			pd_next = 1'b1;
			if (pd_cnt_reg != `PTMC_PD_SETTLE) begin
				pd_cnt_next = pd_cnt_reg + 4'h1;
			end
		end else begin
			pd_next     = 1'b0;
			pd_cnt_next = 4'h0;
			if (pd_reg) begin
				pat_next = decode_pattern(test_pattern_control_reg,
				                          tx_zero_symbol_enable);
			end
		end
		if (soft_reset) begin
			pat_next = ptmc_pkg::PTMC_PAT_NORMAL;
		end
	end

	// Symbol stream: only the data symbols change with the pattern; the
	// transmitter itself sees the same valid timing as in normal use.
	always_comb begin
		run_next     = run_reg;
		phase_next   = phase_reg;
		sym_next     = sym_reg;
		sym_vld_next = 1'b0;
		if (pd_reg) begin
			sym_next = ptmc_pkg::PTMC_SYM_ZERO;
		end else if (tx_sym_valid) begin
			sym_vld_next = 1'b1;
			case (pat_reg)
				ptmc_pkg::PTMC_PAT_ALT: begin
					sym_next   = phase_reg ? ptmc_pkg::PTMC_SYM_MINUS
					                       : ptmc_pkg::PTMC_SYM_PLUS;
					phase_next = ~phase_reg;
				end
				ptmc_pkg::PTMC_PAT_DROOP: begin
					sym_next = phase_reg ? ptmc_pkg::PTMC_SYM_MINUS
					                     : ptmc_pkg::PTMC_SYM_PLUS;
					if (run_reg == `PTMC_DROOP_RUN - 5'h1) begin
						run_next   = 5'h0;
						phase_next = ~phase_reg;
					end else begin
						run_next = run_reg + 5'h1;
					end
				end
				ptmc_pkg::PTMC_PAT_IDLE: begin
					sym_next = idle_sym_valid ? idle_sym_in
					                          : ptmc_pkg::PTMC_SYM_ZERO;
				end
				ptmc_pkg::PTMC_PAT_ZERO: begin
					sym_next = ptmc_pkg::PTMC_SYM_ZERO;
				end
				default: begin
					sym_next = tx_sym_in;
				end
			endcase
		end
		if (pat_reg != pat_next) begin
			run_next   = 5'h0;
			phase_next = 1'b0;
		end
	end

	// Strap is synchronised, then caught once the second stage holds a sample
	// taken after reset release; catching earlier would latch the reset value.
	always_comb begin
		strap_s1_next   = high_level_tx_strap;
		strap_s2_next   = strap_s1_reg;
		strap_cap_next  = strap_cap_reg;
		strap_wait_next = strap_wait_reg;
		if (soft_reset) begin
			strap_wait_next = 2'h0;
		end else if (strap_wait_reg != `PTMC_STRAP_DONE) begin
			strap_wait_next = strap_wait_reg + 2'h1;
			if (strap_wait_reg == `PTMC_STRAP_CATCH) begin
				strap_cap_next = strap_s2_reg;
			end
		end
		// A high strap forbids the high level outright; low permits it but
		// software or autonegotiation may still choose the low level. The
		// high level also stays off until the strap has been caught.
		if (strap_wait_reg != `PTMC_STRAP_DONE || strap_cap_reg) begin
			lvl_next = 1'b0;
		end else begin
			lvl_next = !(sw_low_level_select || an_low_level_result);
		end
	end

	// Registers only.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pd_reg         <= 1'b0;
			pd_cnt_reg     <= 4'h0;
			pat_reg        <= ptmc_pkg::PTMC_PAT_NORMAL;
			run_reg        <= 5'h0;
			phase_reg      <= 1'b0;
			sym_reg        <= ptmc_pkg::PTMC_SYM_ZERO;
			sym_vld_reg    <= 1'b0;
			strap_s1_reg   <= 1'b0;
			strap_s2_reg   <= 1'b0;
			strap_cap_reg  <= 1'b0;
			strap_wait_reg <= 2'h0;
			lvl_reg        <= 1'b0;
		end else begin
			pd_reg         <= pd_next;
			pd_cnt_reg     <= pd_cnt_next;
			pat_reg        <= pat_next;
			run_reg        <= run_next;
			phase_reg      <= phase_next;
			sym_reg        <= sym_next;
			sym_vld_reg    <= sym_vld_next;
			strap_s1_reg   <= strap_s1_next;
			strap_s2_reg   <= strap_s2_next;
			strap_cap_reg  <= strap_cap_next;
			strap_wait_reg <= strap_wait_next;
			lvl_reg        <= lvl_next;
		end
	end

	// Ready is reported only once the settle count has run out.
	assign soft_powerdown_ready_flag = pd_reg && (pd_cnt_reg == `PTMC_PD_SETTLE);
	assign tx_sym_out        = sym_reg;
	assign tx_sym_out_valid  = sym_vld_reg;
	assign force_link_master = (pat_reg == ptmc_pkg::PTMC_PAT_IDLE);
	assign active_pattern    = pat_reg;
	assign tx_level_high     = lvl_reg;
	// Autoneg and forced-link bits and remote loopback are host settings
	// kept by other blocks; they are accepted here for completeness.
	logic unused_cfg;
	assign unused_cfg = autoneg_enable_bit ^ forced_link_enable ^ far_end_loopback_enable;

	ptmc_led_polarity u_led_a (
		.sys_clk           (sys_clk),
		.rst_n             (rst_n),
		.soft_reset        (soft_reset),
		.polarity_mode     (led_a_polarity),
		.pin_in            (indicator_out_a_in),
		.led_on            (led_a_on),
		.pin_out           (indicator_out_a_out),
		.pin_oe_n          (indicator_out_a_oe_n),
		.sensed_active_low (led_sensed_active_low[0])
	);

	ptmc_led_polarity u_led_b (
		.sys_clk           (sys_clk),
		.rst_n             (rst_n),
		.soft_reset        (soft_reset),
		.polarity_mode     (led_b_polarity),
		.pin_in            (indicator_out_b_in),
		.led_on            (led_b_on),
		.pin_out           (indicator_out_b_out),
		.pin_oe_n          (indicator_out_b_oe_n),
		.sensed_active_low (led_sensed_active_low[1])
	);
endmodule : ptmc_test_mode_ctrl

// >>> verif/ptmc_test_mode_ctrl_props.sv
// Concurrent checks on the ports of the transmit test mode control block.
`timescale 1ns/10ps
module ptmc_props (
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic       soft_powerdown_request,
	input wire logic       soft_powerdown_ready_flag,
	input wire logic [1:0] tx_sym_in,
	input wire logic [1:0] tx_sym_out,
	input wire logic       tx_sym_out_valid,
	input wire logic       force_link_master,
	input wire logic [4:0] active_pattern,
	input wire logic       high_level_tx_strap,
	input wire logic       tx_level_high,
	input wire logic       indicator_out_a_oe_n,
	input wire logic       indicator_out_b_oe_n
);
	// All checks share the one clock and are quiet while reset is asserted.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_pd_ready;
		soft_powerdown_request && !$past(soft_powerdown_request) |-> ##[4:5] soft_powerdown_ready_flag;
	endproperty
	a_pd_ready: assert property (p_pd_ready) else $error("ready late");
	property p_pd_quiet;
		soft_powerdown_ready_flag |-> !tx_sym_out_valid;
	endproperty
	a_pd_quiet: assert property (p_pd_quiet) else $error("symbol in power-down");
	property p_alt;
		tx_sym_out_valid && $past(tx_sym_out_valid) && active_pattern == 5'h02
			&& $past(active_pattern) == 5'h02 |-> tx_sym_out != $past(tx_sym_out);
	endproperty
	a_alt: assert property (p_alt) else $error("mode one not alternating");
	property p_zero;
		tx_sym_out_valid && active_pattern == 5'h10 |-> tx_sym_out == 2'h0;
	endproperty
	a_zero: assert property (p_zero) else $error("nonzero symbol when disabled");
	property p_master;
		force_link_master == (active_pattern == 5'h08);
	endproperty
	a_master: assert property (p_master) else $error("master flag wrong");
	property p_strap;
		high_level_tx_strap [*8] |-> !tx_level_high;
	endproperty
	a_strap: assert property (p_strap) else $error("high level with strap");
	property p_led_release;
		$rose(rst_n) |-> indicator_out_a_oe_n && indicator_out_b_oe_n;
	endproperty
	a_led_release: assert property (p_led_release) else $error("pin driven in sense");
	property p_normal;
		tx_sym_out_valid && active_pattern == 5'h01 |-> tx_sym_out == $past(tx_sym_in);
	endproperty
	a_normal: assert property (p_normal) else $error("normal symbol altered");
endmodule : ptmc_props
bind ptmc_test_mode_ctrl ptmc_props u_props (.*);

// >>> verif/ptmc_line_partner.sv
// Remote line partner with the board pulls on the two indicator pins.
`timescale 1ns/10ps
module ptmc_line_partner (
	input wire logic        sys_clk,
	input wire logic [1:0]  sym,
	input wire logic        sym_valid,
	output logic [1:0]      loop_sym,
	output logic            loop_valid,
	input wire logic [1:0]  pin_out,
	input wire logic [1:0]  pin_oe_n,
	output logic [1:0]      pin_wire
);
	// Received symbols return one slot later, as the far end loops them back.
	always_ff @(posedge sys_clk) begin
		loop_sym   <= sym;
		loop_valid <= sym_valid;
	end
	// A released pin a floats high and pin b floats low, so autosense has a level.
	assign pin_wire[0] = pin_oe_n[0] ? 1'b1 : pin_out[0];
	assign pin_wire[1] = pin_oe_n[1] ? 1'b0 : pin_out[1];
endmodule : ptmc_line_partner

// >>> verif/ptmc_test_mode_ctrl_tb.sv
// Self-checking bench for the transmit test mode control block.
`timescale 1ns/10ps
module ptmc_test_mode_ctrl_tb;
	typedef struct {logic [2:0] sel; logic zero; logic [4:0] pat;} ptmc_row_t;
	logic        clk = 1'b0, rst_n = 1'b0, srst = 1'b0, req = 1'b0, rdy, an = 1'b1, frc = 1'b0;
	logic        zen = 1'b0, sv = 1'b0, iv = 1'b0, sov, mst, lvl, lb = 1'b0, lv;
	logic        strap = 1'b0, swl = 1'b0, anl = 1'b0;
	logic [15:0] ctl = 16'h0000;
	logic [1:0]  si = 2'h0, ii = 2'h0, so, pa = 2'h0, pb = 2'h0, on = 2'h0, po, poe, pw, sen, ls;
	logic [4:0]  pat;
	int          mismatches = 0, checks = 0, cycles = 0, i, r;
	ptmc_row_t   rows [7] = '{'{3'h1, 1'b0, 5'h02}, '{3'h2, 1'b0, 5'h04}, '{3'h3, 1'b0, 5'h08},
		'{3'h0, 1'b0, 5'h01}, '{3'h3, 1'b1, 5'h10}, '{3'h5, 1'b0, 5'h01}, '{3'h7, 1'b0, 5'h01}};
	ptmc_test_mode_ctrl dut (.sys_clk(clk), .rst_n(rst_n), .soft_reset(srst),
		.soft_powerdown_request(req), .soft_powerdown_ready_flag(rdy), .autoneg_enable_bit(an),
		.forced_link_enable(frc), .test_pattern_control_reg(ctl), .tx_zero_symbol_enable(zen),
		.far_end_loopback_enable(lb), .tx_sym_valid(sv), .tx_sym_in(si), .idle_sym_valid(iv),
		.idle_sym_in(ii), .tx_sym_out(so), .tx_sym_out_valid(sov), .force_link_master(mst),
		.active_pattern(pat), .high_level_tx_strap(strap), .sw_low_level_select(swl),
		.an_low_level_result(anl), .tx_level_high(lvl), .led_a_polarity(pa), .led_b_polarity(pb),
		.led_a_on(on[0]), .led_b_on(on[1]), .indicator_out_a_in(pw[0]), .indicator_out_a_out(po[0]),
		.indicator_out_a_oe_n(poe[0]), .indicator_out_b_in(pw[1]), .indicator_out_b_out(po[1]),
		.indicator_out_b_oe_n(poe[1]), .led_sensed_active_low(sen));
	ptmc_line_partner partner (.sys_clk(clk), .sym(so), .sym_valid(sov), .loop_sym(ls),
		.loop_valid(lv), .pin_out(po), .pin_oe_n(poe), .pin_wire(pw));
	// Free-running clock and a hang guard well beyond the expected run length.
	always #10 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		if (mismatches == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input string nm, input logic [4:0] exp, input logic [4:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// Inputs always change two nanoseconds after the rising edge.
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : tick
	function automatic logic [1:0] in_sym(input int n, input int k);
		return k ? (n % 4 > 1 ? 2'h3 : 2'h0) : (n % 3 == 0 ? 2'h1 : n % 3 == 1 ? 2'h3 : 2'h0);
	endfunction : in_sym
	function automatic logic [1:0] exp_sym(input logic [4:0] p, input int n);
		case (p)
			5'h02: return n % 2 ? 2'h3 : 2'h1;
			5'h04: return n % 20 < 10 ? 2'h1 : 2'h3;
			5'h08: return in_sym(n, 1);
			5'h10: return 2'h0;
			default: return in_sym(n, 0);
		endcase
	endfunction : exp_sym
	// Host sequence: power down, confirm, force link, pick the mode, power up.
	task automatic enter(input ptmc_row_t w);
		req = 1'b1;
		r = 0;
		tick(1);
		while (rdy !== 1'b1 && r < 20) begin
			tick(1);
			r++;
		end
		chk("ready", 5'h01, {4'h0, rdy});
		an = 1'b0;
		frc = 1'b1;
		ctl = {w.sel, 13'h0000};
		zen = w.zero;
		tick(1);
		req = 1'b0;
		tick(3);
	endtask : enter
	// Reset, level and indicator cases first, then the table of modes, then strap and soft reset.
	initial begin
		tick(16);
		chk("reset pattern", 5'h01, pat);
		chk("reset outputs", 5'h03, {lvl, rdy, sov, poe});
		rst_n = 1'b1;
		tick(12);
		chk("sensed", 5'h01, {3'h0, sen});
		chk("level", 5'h01, {4'h0, lvl});
		swl = 1'b1;
		tick(3);
		chk("level sw", 5'h00, {4'h0, lvl});
		{swl, anl} = 2'b01;
		tick(3);
		chk("level an", 5'h00, {4'h0, lvl});
		{anl, on} = 3'b011;
		tick(3);
		chk("auto pins", 5'h02, {1'b0, poe, pw});
		{pa, pb} = 4'b0110;
		tick(3);
		chk("forced pins", 5'h01, {1'b0, poe, pw});
		lb = 1'b1;
		foreach (rows[k]) begin
			enter(rows[k]);
			chk("pattern", rows[k].pat, pat);
			chk("master", {4'h0, rows[k].pat == 5'h08}, {4'h0, mst});
			iv = 1'b1;
			for (i = 0; i < 25; i++) begin
				{sv, si, ii} = {1'b1, in_sym(i, 0), in_sym(i, 1)};
				tick(1);
				chk("symbol", {2'h0, 1'b1, exp_sym(rows[k].pat, i)}, {2'h0, sov, so});
				if (i > 0) begin
					chk("loop", {3'h1, exp_sym(rows[k].pat, i - 1)}, {2'h0, lv, ls});
				end
			end
			sv = 1'b0;
			tick(2);
		end
		{rst_n, strap} = 2'b01;
		tick(16);
		rst_n = 1'b1;
		tick(12);
		chk("strap level", 5'h00, {4'h0, lvl});
		enter(rows[0]);
		{strap, srst} = 2'b01;
		tick(1);
		chk("soft release", 5'h03, {3'h0, poe});
		srst = 1'b0;
		tick(12);
		chk("soft pattern", 5'h01, pat);
		chk("soft level", 5'h01, {4'h0, lvl});
		chk("soft sensed", 5'h01, {3'h0, sen});
		print_verdict();
	end
endmodule : ptmc_test_mode_ctrl_tb
